// ### dv/adcsq_ana_model.sv
// Analog mux, fixed input levels and comparator model
`timescale 1ns/1ps
module adcsq_ana_model (
  // Mux and trial code in, comparator out
  input wire logic [5:0] sel_i,
  input wire logic bias_i,
  input wire logic [9:0] dac_i,
  output logic cmp_o
);
  logic [9:0] vin;
  // Fixed level per channel, bias level when selected
  always_comb
  begin
    vin = bias_i ? 10'h0ed : 10'h000;
    for (int k = 0; k < 6; k++)
      if (sel_i[k]) vin = 10'h0a5 + 10'(k) * 10'h0b3;
    cmp_o = vin >= dac_i;
  end
endmodule // adcsq_ana_model

// ### dv/adcsq_chk.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module adcsq_chk (
  // Watched ports
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  input wire logic [3:0] channel_select_i,
  input wire logic conversion_start_wr_i,
  input wire logic irq_clear_i,
  input wire logic irq_ack_i,
  input wire logic [5:0] analog_input_sel_o,
  input wire logic conversion_start_bit_o,
  input wire logic conversion_done_bit_o,
  input wire logic converter_irq_flag_o,
  input wire logic [7:0] result_lower_reg_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  // Start request and software clear
  sequence s_start; conversion_start_wr_i; endsequence
  sequence s_clr; (irq_clear_i || irq_ack_i) ##1 !$rose(conversion_done_bit_o); endsequence
  // Rules on the ports
  property p_start; s_start |=> conversion_start_bit_o ##1 !conversion_start_bit_o; endproperty
  a_start: assert property (p_start) else $error("start bit not a pulse");
  property p_busy; s_start |=> !conversion_done_bit_o [*8]; endproperty
  a_busy: assert property (p_busy) else $error("done high while busy");
  property p_time; s_start |-> ##[55:419] $rose(conversion_done_bit_o); endproperty
  a_time: assert property (p_time) else $error("conversion length wrong");
  property p_irq; $rose(conversion_done_bit_o) |-> converter_irq_flag_o; endproperty
  a_irq: assert property (p_irq) else $error("irq not set on done");
  property p_hold; $changed(result_lower_reg_o) |-> $rose(conversion_done_bit_o); endproperty
  a_hold: assert property (p_hold) else $error("result changed early");
  property p_stick; converter_irq_flag_o && !irq_clear_i && !irq_ack_i |=> converter_irq_flag_o;
  endproperty
  a_stick: assert property (p_stick) else $error("irq dropped");
  property p_clr; s_clr |-> !converter_irq_flag_o; endproperty
  a_clr: assert property (p_clr) else $error("irq not cleared");
  property p_mux; s_start and (channel_select_i < 4'h6) |=>
    analog_input_sel_o == 6'h01 << $past(channel_select_i); endproperty
  a_mux: assert property (p_mux) else $error("mux select wrong");
endmodule // adcsq_chk
bind adcsq_ctrl adcsq_chk adcsq_chk_inst (.core_clk_i, .arst_n_i, .channel_select_i,
  .conversion_start_wr_i, .irq_clear_i, .irq_ack_i, .analog_input_sel_o,
  .conversion_start_bit_o, .conversion_done_bit_o, .converter_irq_flag_o, .result_lower_reg_o);

// ### dv/adcsq_ctrl_tb_top.sv
// Testbench for the converter sequencer
`timescale 1ns/1ps
module adcsq_ctrl_tb_top;
  logic core_clk_i = 0, arst_n_i = 0, conversion_start_wr_i = 0, upper_wr_i = 0;
  logic upper_mode8_i = 0, irq_clear_i = 0, irq_ack_i = 0, comparator_i;
  logic [3:0] channel_select_i = 4'h0;
  logic [1:0] upper_clk_sel_i = 2'h0;
  logic [5:0] analog_input_sel_o;
  logic [9:0] dac_code_o;
  logic [7:0] result_upper_reg_o, result_lower_reg_o;
  logic bias_ref_sel_o, conversion_start_bit_o, conversion_done_bit_o, converter_irq_flag_o;
  logic sample_hold_o;
  int n_fail = 0, checks = 0;
  // Design and far side
  adcsq_ctrl adcsq_ctrl_inst (.core_clk_i, .arst_n_i, .channel_select_i, .conversion_start_wr_i,
    .upper_wr_i, .upper_clk_sel_i, .upper_mode8_i, .irq_clear_i, .irq_ack_i, .comparator_i,
    .analog_input_sel_o, .bias_ref_sel_o, .sample_hold_o, .dac_code_o, .conversion_start_bit_o,
    .conversion_done_bit_o, .converter_irq_flag_o, .result_upper_reg_o, .result_lower_reg_o);
  adcsq_ana_model adcsq_ana_model_inst (.sel_i(analog_input_sel_o), .bias_i(bias_ref_sel_o),
    .dac_i(dac_code_o), .cmp_o(comparator_i));
  // Clock
  always #2.5 core_clk_i = ~core_clk_i;
  task automatic print_verdict();
    if (n_fail == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(string n, logic [9:0] e, logic [9:0] g);
    checks++;
    if (e !== g)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr_up(logic [1:0] c, logic m);
    upper_clk_sel_i = c;
    upper_mode8_i = m;
    upper_wr_i = 1;
    tick();
    upper_wr_i = 0;
  endtask
  task automatic conv(logic [3:0] ch, int p);
    int n;
    logic h;
    h = 1'b0;
    channel_select_i = ch;
    conversion_start_wr_i = 1;
    tick();
    conversion_start_wr_i = 0;
    cmp("start", 1, conversion_start_bit_o);
    cmp("done", 0, conversion_done_bit_o);
    n = 0;
    while (conversion_done_bit_o !== 1'b1 && n < 1000)
    begin
      h = h | sample_hold_o;
      tick();
      n++;
    end
    cmp("span", 1, n >= 13 * p && n <= 13 * p + 2);
    cmp("hold", 1, h);
    cmp("irq", 1, converter_irq_flag_o);
  endtask
  // Watchdog
  initial
  begin
    #50us;
    n_fail++;
    print_verdict();
  end
  // Tests
  initial
  begin
    repeat (12) @(posedge core_clk_i);
    #1 arst_n_i = 1;
    cmp("upper", 0, result_upper_reg_o);
    for (int k = 0; k < 7; k++)
    begin
      wr_up(2'(k), 0);
      conv(k < 6 ? 4'(k) : 4'hf, 4 << (k % 4));
      cmp("result", k < 6 ? 10'h0a5 + 10'(k) * 10'h0b3 : 10'h0ed,
        {result_upper_reg_o[1:0], result_lower_reg_o});
      cmp("clksel", 10'(k % 4), result_upper_reg_o[7:6]);
    end
    wr_up(1, 1);
    conv(2, 8);
    cmp("lower8", 10'h20b >> 2, result_lower_reg_o);
    irq_clear_i = 1;
    tick();
    irq_clear_i = 0;
    cmp("irqclr", 0, converter_irq_flag_o);
    conv(4'hf, 8);
    cmp("bias8", 10'h0ed >> 2, result_lower_reg_o);
    irq_ack_i = 1;
    tick();
    irq_ack_i = 0;
    cmp("irqack", 0, converter_irq_flag_o);
    print_verdict();
  end
endmodule // adcsq_ctrl_tb_top

// ### logic/adcsq_clkdiv.sv
// Converter clock tick generator with four selectable division ratios
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_clkdiv (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic [1:0] clk_sel_i,
  input wire logic restart_i,
  // Tick out
  output logic tick_o
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } adcsq_div_t;

  adcsq_div_t s_q;
  adcsq_div_t s_d;
  logic [7:0] limit;

  // Division limit per selection
  always_comb
  begin
    unique case (clk_sel_i)
      2'h0: limit = `ADCSQ_DIV0;
      2'h1: limit = `ADCSQ_DIV1;
      2'h2: limit = `ADCSQ_DIV2;
      2'h3: limit = `ADCSQ_DIV3;
    endcase
  end

  // Counter, restartable so a conversion starts on a full period
  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (restart_i)
    begin
      s_d.cnt = 8'h00;
    end
    else if (s_q.cnt >= limit)
    begin
      s_d.cnt = 8'h00;
      s_d.tick = 1'b1;
    end
    else
    begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign tick_o = s_q.tick;
endmodule // adcsq_clkdiv

// ### logic/adcsq_consts.svh
// Constants for the converter sequencer: field positions, reset values, timing
`ifndef ADCSQ_CONSTS_SVH
`define ADCSQ_CONSTS_SVH
`define ADCSQ_RES_W 10
`define ADCSQ_NUM_CH 6
`define ADCSQ_BIAS_SEL 4'hf
`define ADCSQ_CONV_CLKS 13
`define ADCSQ_UPR_CLKSEL_HI 7
`define ADCSQ_UPR_CLKSEL_LO 6
`define ADCSQ_UPR_MODE8_BIT 5
`define ADCSQ_UPR_RESET 8'h00
`define ADCSQ_LWR_RESET 8'h00
`define ADCSQ_CLKSEL_RESET 2'h0
`define ADCSQ_DIV0 8'h03
`define ADCSQ_DIV1 8'h07
`define ADCSQ_DIV2 8'h0f
`define ADCSQ_DIV3 8'h1f
`endif

// ### logic/adcsq_ctrl.sv
// Successive-approximation converter sequencer with control and result registers
//
// Behaviour
// - Converts the selected analog input into a ten-bit result.
// - One of six inputs routed through a shared mux to one sample-hold.
// - Result found by successive approximation, one bit per step.
// - Upper result register bits 7:6 are writable converter clock select.
// - Four-bit channel select; software sets the port pin to input first.
// - Select value all ones feeds the internal bias reference.
// - Writing one to start begins conversion; hardware clears start next cycle.
// - Normal mode splits ten-bit result across upper and lower registers.
// - Eight-bit mode places eight-bit result wholly in lower register.
// - Completion loads results, sets done bit and interrupt request flag.
// - Done bit reads zero while converting, one when finished.
// - Each conversion takes thirteen converter clock periods.
`timescale 1ns/1ps
`include "adcsq_consts.svh"
module adcsq_ctrl #(
  parameter int RES_W = `ADCSQ_RES_W,
  parameter int NUM_CH = `ADCSQ_NUM_CH
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // Control register writes
  input wire logic [3:0] channel_select_i,
  input wire logic conversion_start_wr_i,
  input wire logic upper_wr_i,
  input wire logic [1:0] upper_clk_sel_i,
  input wire logic upper_mode8_i,
  input wire logic irq_clear_i,
  input wire logic irq_ack_i,
  // Analog side
  input wire logic comparator_i,
  output logic [NUM_CH-1:0] analog_input_sel_o,
  output logic bias_ref_sel_o,
  output logic sample_hold_o,
  output logic [RES_W-1:0] dac_code_o,
  // Status and results
  output logic conversion_start_bit_o,
  output logic conversion_done_bit_o,
  output logic converter_irq_flag_o,
  output logic [7:0] result_upper_reg_o,
  output logic [7:0] result_lower_reg_o
);
  typedef struct packed {
    adcsq_pkg::adcsq_state_t st;
    logic [3:0] step;
    logic [3:0] bitidx;
    logic [RES_W-1:0] sar;
    logic [3:0] chan;
    logic start;
    logic done;
    logic irq;
    logic [1:0] clksel;
    logic mode8;
    logic [7:0] upper;
    logic [7:0] lower;
    logic [NUM_CH-1:0] mux;
    logic bias;
    logic hold;
  } adcsq_ctrl_t;

  adcsq_ctrl_t s_q;
  adcsq_ctrl_t s_d;
  logic tick;
  logic cmp_meta_q;
  logic cmp_sync_q;

  // Converter clock ticks, restarted with each start
  adcsq_clkdiv u_clkdiv (
    .core_clk_i(core_clk_i),
    .arst_n_i(arst_n_i),
    .clk_sel_i(s_q.clksel),
    .restart_i(s_q.start),
    .tick_o(tick)
  );

  // Comparator arrives from the analog side: two-stage synchroniser
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmp_meta_q <= 1'b0;
      cmp_sync_q <= 1'b0;
    end
    else
    begin
      cmp_meta_q <= comparator_i;
      cmp_sync_q <= cmp_meta_q;
    end
  end

  // Sequencer: 1 sample period, RES_W approximation steps, 2 settle/load periods
  always_comb
  begin
    s_d = s_q;
    s_d.start = 1'b0;
    if (upper_wr_i)
    begin
      s_d.clksel = upper_clk_sel_i;
      s_d.mode8 = upper_mode8_i;
    end
    if (irq_clear_i || irq_ack_i)
    begin
      s_d.irq = 1'b0;
    end
    s_d.chan = channel_select_i;
    if (conversion_start_wr_i)
    begin
      s_d.start = 1'b1;
      s_d.done = 1'b0;
      s_d.st = adcsq_pkg::ADCSQ_SAMPLE;
      s_d.step = 4'h0;
      s_d.hold = 1'b0;
      // Channel decode into the shared mux
      s_d.bias = (channel_select_i == `ADCSQ_BIAS_SEL);
      for (int i = 0; i < NUM_CH; i++)
      begin
        s_d.mux[i] = (channel_select_i == 4'(i));
      end
    end
    else if (tick && !s_q.start)
    begin
      // A tick left over from before the restart would shorten the first period
      s_d.step = s_q.step + 4'h1;
      unique case (s_q.st)
        adcsq_pkg::ADCSQ_IDLE:
        begin
          s_d.step = s_q.step;
        end
        adcsq_pkg::ADCSQ_SAMPLE:
        begin
          s_d.hold = 1'b1;
          s_d.bitidx = 4'(RES_W - 1);
          s_d.sar = '0;
          s_d.sar[RES_W-1] = 1'b1;
          s_d.st = adcsq_pkg::ADCSQ_APPROX;
        end
        adcsq_pkg::ADCSQ_APPROX:
        begin
          // Keep or drop the trial bit, then try the next one
          if (!cmp_sync_q)
          begin
            s_d.sar[s_q.bitidx] = 1'b0;
          end
          if (s_q.bitidx == 4'h0)
          begin
            s_d.st = adcsq_pkg::ADCSQ_LOAD;
          end
          else
          begin
            s_d.bitidx = s_q.bitidx - 4'h1;
            s_d.sar[s_q.bitidx - 4'h1] = 1'b1;
          end
        end
        adcsq_pkg::ADCSQ_LOAD:
        begin
          if (s_q.step == 4'(`ADCSQ_CONV_CLKS - 1))
          begin
            s_d.st = adcsq_pkg::ADCSQ_IDLE;
            s_d.hold = 1'b0;
            s_d.done = 1'b1;
            s_d.irq = 1'b1;
            if (s_q.mode8)
            begin
              s_d.lower = s_q.sar[RES_W-1 -: 8];
            end
            else
            begin
              s_d.lower = s_q.sar[7:0];
              s_d.upper[1:0] = s_q.sar[RES_W-1 -: 2];
            end
          end
        end
      endcase
    end
    // Upper register also carries the writable control bits
    s_d.upper[`ADCSQ_UPR_CLKSEL_HI:`ADCSQ_UPR_CLKSEL_LO] = s_d.clksel;
    s_d.upper[`ADCSQ_UPR_MODE8_BIT] = s_d.mode8;
  end

  // State register; results untouched except on completion
  always_ff @(posedge core_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_q <= '0;
      s_q.st <= adcsq_pkg::ADCSQ_IDLE;
      s_q.clksel <= `ADCSQ_CLKSEL_RESET;
      s_q.upper <= `ADCSQ_UPR_RESET;
      s_q.lower <= `ADCSQ_LWR_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs straight from state flip-flops
  assign analog_input_sel_o = s_q.mux;
  assign bias_ref_sel_o = s_q.bias;
  assign sample_hold_o = s_q.hold;
  assign dac_code_o = s_q.sar;
  assign conversion_start_bit_o = s_q.start;
  assign conversion_done_bit_o = s_q.done;
  assign converter_irq_flag_o = s_q.irq;
  assign result_upper_reg_o = s_q.upper;
  assign result_lower_reg_o = s_q.lower;
endmodule // adcsq_ctrl

// ### logic/adcsq_pkg.sv
// Types for the converter sequencer
package adcsq_pkg;
  typedef enum logic [1:0] {
    ADCSQ_IDLE,
    ADCSQ_SAMPLE,
    ADCSQ_APPROX,
    ADCSQ_LOAD
  } adcsq_state_t;
endpackage
